// file: rtl/mrssm_pkg.sv
`default_nettype none
package mrssm_pkg;
	// ==========================================================
	// Widths
	localparam int X_W = 22;
	localparam int CTRL_W = 8;
	localparam int MODE_W = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int ARRAY_W_DEF = 32;
	localparam int CNT_W_DEF = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_INPUT_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATS_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_THR_BUF = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_THR_COPY = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CNT_BUF = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CNT_COPY = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_LIVE_STATUS = 8'h18;

	// ==========================================================
	// Field positions
	localparam int CASC_SEL_BIT = 0;
	localparam int SHIFT_LSB = 1;
	localparam int SHIFT_MSB = 5;
	localparam int RECT_LSB = 6;
	localparam int RECT_MSB = 7;
	localparam int POS_FLAG_BIT = 22;
	localparam int NEG_FLAG_BIT = 23;
	localparam int COPY_CAPTURE_BIT = 0;

	// ==========================================================
	// Reset values and limits
	localparam logic [CTRL_W-1:0] INPUT_CTRL_RST = 8'h00;
	localparam logic [MODE_W-1:0] STATS_MODE_RST = 2'h0;
	localparam logic [X_W-1:0] THR_RST = 22'h000000;
	localparam int MAX_SHIFT = 8;
	localparam int X_MAX = (1 <<< (X_W - 1)) - 1;
	localparam int X_MIN = -(1 <<< (X_W - 1));
	localparam logic [X_W-1:0] X_MIN_BITS = 22'h200000;

	// ==========================================================
	// Encodings
	typedef enum logic [1:0]
	{
		MODE_MIN = 2'b00,
		MODE_MAX = 2'b01,
		MODE_UNDER = 2'b10,
		MODE_OVER = 2'b11
	} mrssm_mode_t;

	localparam logic [1:0] RECT_PASS = 2'h0;
	localparam logic [1:0] RECT_HALF = 2'h1;

	typedef struct packed
	{
		logic valid;
		logic signed [X_W-1:0] xBus;
		logic posOvf;
		logic negOvf;
	} mrssm_stage_t;
endpackage
`default_nettype wire

// file: rtl/mrssm_stage_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mrssm_stage_if;
	logic [mrssm_pkg::CTRL_W-1:0] ctrl;
	logic valid;
	logic signed [mrssm_pkg::X_W-1:0] xBus;
	logic posOvf;
	logic negOvf;
	modport producer (input ctrl, output valid, xBus, posOvf, negOvf);
	modport consumer (output ctrl, input valid, xBus, posOvf, negOvf);
endinterface
`default_nettype wire

// file: rtl/mrssm_input_stage.sv
`timescale 1ns/1ps
`default_nettype none
module mrssm_input_stage #(
	parameter int ARRAY_W = mrssm_pkg::ARRAY_W_DEF
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic signed [ARRAY_W-1:0] macResult,
	input wire logic signed [mrssm_pkg::X_W-1:0] cascadeIn,
	input wire logic sampleValid,
	mrssm_stage_if.producer stage
);
	localparam int SUM_W = ARRAY_W + 2;

	mrssm_pkg::mrssm_stage_t state_reg;
	mrssm_pkg::mrssm_stage_t state_next;
	logic signed [4:0] shiftCode;
	logic [4:0] shiftMag;
	logic [3:0] shiftAmt;
	logic shiftRight;
	logic signed [ARRAY_W-1:0] shifted;
	logic signed [ARRAY_W-1:0] roundVec;
	logic roundBit;
	logic signed [SUM_W-1:0] cascOperand;
	logic signed [SUM_W-1:0] sumWide;
	logic signed [mrssm_pkg::X_W-1:0] sumX;
	logic [1:0] rectSel;
	logic posNow;
	logic negNow;

	// ==========================================================
	// Shifter, cascade adder, rectifier
	always_comb
	begin
		state_next = state_reg;
		shiftCode = signed'(stage.ctrl[mrssm_pkg::SHIFT_MSB:mrssm_pkg::SHIFT_LSB]); // RL1
		shiftRight = shiftCode[4];
		shiftMag = shiftRight ? 5'(-shiftCode) : 5'(shiftCode);
		// Codes beyond eight places clamp rather than wrap
		shiftAmt = (shiftMag > 5'(mrssm_pkg::MAX_SHIFT)) ? 4'(mrssm_pkg::MAX_SHIFT) : shiftMag[3:0];
		roundVec = macResult;
		roundBit = 1'b0;
		if (shiftRight && shiftAmt != 4'h0)
		begin
			roundVec = macResult >>> (shiftAmt - 4'h1);
			roundBit = roundVec[0]; // RL3
			shifted = macResult >>> shiftAmt; // RL1
		end
		else
		begin
			// Bits pushed out on the left are lost silently
			shifted = macResult <<< shiftAmt; // RL1 RL2
		end
		cascOperand = stage.ctrl[mrssm_pkg::CASC_SEL_BIT] ? SUM_W'(cascadeIn) : SUM_W'(0); // RL4
		sumWide = SUM_W'(shifted) + cascOperand + SUM_W'({1'b0, roundBit}); // RL3 RL4
		posNow = sumWide > SUM_W'(mrssm_pkg::X_MAX); // RL5
		negNow = sumWide < SUM_W'(mrssm_pkg::X_MIN); // RL5
		sumX = sumWide[mrssm_pkg::X_W-1:0];
		rectSel = stage.ctrl[mrssm_pkg::RECT_MSB:mrssm_pkg::RECT_LSB];
		state_next.valid = sampleValid; // RL21
		state_next.posOvf = sampleValid & posNow;
		state_next.negOvf = sampleValid & negNow;
		if (rectSel == mrssm_pkg::RECT_PASS)
		begin
			state_next.xBus = sumX; // RL20
		end
		else if (rectSel == mrssm_pkg::RECT_HALF)
		begin
			state_next.xBus = sumX[mrssm_pkg::X_W-1] ? '0 : sumX; // RL6 RL20
		end
		else if (sumX[mrssm_pkg::X_W-1] && sumX != mrssm_pkg::X_MIN_BITS)
		begin
			state_next.xBus = -sumX; // RL6 RL20
		end
		else
		begin
			// Most negative value has no positive twin
			state_next.xBus = sumX; // RL7
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg <= '0; // RL21
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign stage.valid = state_reg.valid;
	assign stage.xBus = state_reg.xBus; // RL19
	assign stage.posOvf = state_reg.posOvf;
	assign stage.negOvf = state_reg.negOvf;

	// ==========================================================
	// Checks
	property p_half_nonneg;
		@(posedge clk) disable iff (reset)
		sampleValid && rectSel == mrssm_pkg::RECT_HALF |=> !stage.xBus[mrssm_pkg::X_W-1];
	endproperty
	a_half_nonneg: assert property (p_half_nonneg) // RL20
		else $error("half-wave output negative");

	property p_full_min;
		@(posedge clk) disable iff (reset)
		sampleValid && rectSel[1] && sumX == mrssm_pkg::X_MIN_BITS
			|=> stage.xBus == mrssm_pkg::X_MIN_BITS;
	endproperty
	a_full_min: assert property (p_full_min) // RL7
		else $error("most negative value altered by full-wave");

	property p_pos_ovf;
		@(posedge clk) disable iff (reset)
		sampleValid |=> stage.posOvf == ($past(sumWide) > SUM_W'(mrssm_pkg::X_MAX));
	endproperty
	a_pos_ovf: assert property (p_pos_ovf) // RL5
		else $error("positive overflow flag wrong");
endmodule
`default_nettype wire

// file: rtl/mrssm_scaler_stats.sv
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] Arithmetic shift of array result, up to eight places, set by 5-bit field.
// [RL2] Left-shift overflow is neither detected nor flagged.
// [RL3] Right shifts produce a rounding bit added into the sum.
// [RL4] Sum is shifted value plus round bit plus cascade input or zero.
// [RL5] Flag positive overflow above 2^21-1, negative below -2^21.
// [RL6] Two-bit field selects pass, half-wave or full-wave rectification onto X bus.
// [RL7] Full-wave keeps the most negative value unchanged.
// [RL8] Mode bits: 01 max, 00 min, 11 overshoot, 10 undershoot.
// [RL9] Max mode: larger X loads threshold and bumps counter.
// [RL10] Min mode: smaller X loads threshold and bumps counter.
// [RL11] Max or min modes never update threshold in an overflow cycle.
// [RL12] Overshoot mode counts X above threshold or positive overflow.
// [RL13] Undershoot mode counts X below threshold.
// [RL14] Event counter is unsigned and saturates at its maximum.
// [RL15] Sticky flags: positive overflow bit 22, negative overflow bit 23.
// [RL16] Writing the threshold copy location clears the sticky flags.
// [RL17] Threshold and counter reached only through buffers and copy locations.
// [RL18] Software presets threshold to most negative value before max tracking.
// [RL19] X bus is 22-bit signed two's complement.
// [RL20] Rectifier codes: 00 pass, 01 negatives to zero, 1x absolute value.
// [RL21] Everything runs on the system clock; reset clears counter, flags, threshold.
module mrssm_scaler_stats #(
	parameter int ARRAY_W = mrssm_pkg::ARRAY_W_DEF,
	parameter int CNT_W = mrssm_pkg::CNT_W_DEF
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic [mrssm_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [mrssm_pkg::DATA_W-1:0] writedata,
	input wire logic [mrssm_pkg::BE_W-1:0] byteenable,
	output logic [mrssm_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic signed [ARRAY_W-1:0] macResult,
	input wire logic signed [mrssm_pkg::X_W-1:0] cascadeIn,
	input wire logic sampleValid,
	output logic signed [mrssm_pkg::X_W-1:0] xBus,
	output logic xValid,
	output logic posOverflow,
	output logic negOverflow
);
	// ==========================================================
	// State
	typedef struct packed
	{
		logic [mrssm_pkg::CTRL_W-1:0] inputCtrl;
		logic [mrssm_pkg::MODE_W-1:0] statsMode;
		logic [mrssm_pkg::X_W+1:0] thresholdBuffer;
		logic [CNT_W-1:0] counterBuffer;
		logic signed [mrssm_pkg::X_W-1:0] threshold;
		logic posFlag;
		logic negFlag;
		logic [CNT_W-1:0] eventCount;
		logic waitReq;
		logic [mrssm_pkg::DATA_W-1:0] readData;
	} mrssm_regs_t;

	mrssm_regs_t state_reg;
	mrssm_regs_t state_next;
	logic busReq;
	logic busAccept;
	logic busCommit;
	logic [mrssm_pkg::DATA_W-1:0] mergedWrite;
	logic thrCopyWr;
	logic cntCopyWr;
	logic statsHit;
	logic thrHwLoad;
	logic anyOvf;
	logic [mrssm_pkg::DATA_W-1:0] readMux;

	mrssm_stage_if stage ();

	mrssm_input_stage #(
		.ARRAY_W(ARRAY_W)
	) inputStage (
		.clk(clk),
		.reset(reset),
		.macResult(macResult),
		.cascadeIn(cascadeIn),
		.sampleValid(sampleValid),
		.stage(stage)
	);

	assign stage.ctrl = state_reg.inputCtrl;

	// ==========================================================
	// Byte-lane merge for partial writes
	function automatic logic [mrssm_pkg::DATA_W-1:0] mrssmMerge(
		input logic [mrssm_pkg::DATA_W-1:0] oldVal,
		input logic [mrssm_pkg::DATA_W-1:0] newVal,
		input logic [mrssm_pkg::BE_W-1:0] be
	);
		logic [mrssm_pkg::DATA_W-1:0] res;
		res = oldVal;
		for (int i = 0; i < mrssm_pkg::BE_W; i++)
		begin
			if (be[i])
			begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ==========================================================
	// Bus decode
	always_comb
	begin
		busReq = read | write;
		busAccept = busReq & state_reg.waitReq;
		busCommit = busReq & ~state_reg.waitReq;
		thrCopyWr = busCommit && write && address == mrssm_pkg::OFF_THR_COPY; // RL17
		cntCopyWr = busCommit && write && address == mrssm_pkg::OFF_CNT_COPY; // RL17
		mergedWrite = writedata;
		case (address)
			mrssm_pkg::OFF_INPUT_CTRL:
				mergedWrite = mrssmMerge(32'(state_reg.inputCtrl), writedata, byteenable);
			mrssm_pkg::OFF_STATS_MODE:
				mergedWrite = mrssmMerge(32'(state_reg.statsMode), writedata, byteenable);
			mrssm_pkg::OFF_THR_BUF:
				mergedWrite = mrssmMerge(32'(state_reg.thresholdBuffer), writedata, byteenable);
			mrssm_pkg::OFF_CNT_BUF:
				mergedWrite = mrssmMerge(32'(state_reg.counterBuffer), writedata, byteenable);
			default:
				mergedWrite = writedata;
		endcase
		readMux = '0;
		case (address)
			mrssm_pkg::OFF_INPUT_CTRL:
				readMux = 32'(state_reg.inputCtrl);
			mrssm_pkg::OFF_STATS_MODE:
				readMux = 32'(state_reg.statsMode);
			mrssm_pkg::OFF_THR_BUF:
				readMux = 32'(state_reg.thresholdBuffer);
			mrssm_pkg::OFF_CNT_BUF:
				readMux = 32'(state_reg.counterBuffer);
			mrssm_pkg::OFF_LIVE_STATUS:
				readMux = 32'({state_reg.negFlag, state_reg.posFlag, stage.xBus});
			default:
				// Copy locations and holes read as zero
				readMux = '0;
		endcase
	end

	// ==========================================================
	// Statistics decision
	always_comb
	begin
		anyOvf = stage.posOvf | stage.negOvf;
		statsHit = 1'b0;
		thrHwLoad = 1'b0;
		case (mrssm_pkg::mrssm_mode_t'(state_reg.statsMode)) // RL8
			mrssm_pkg::MODE_MAX:
			begin
				// Overflowed samples would leave a misleading extreme
				statsHit = stage.valid && !anyOvf && stage.xBus > state_reg.threshold; // RL9 RL11
				thrHwLoad = statsHit; // RL9
			end
			mrssm_pkg::MODE_MIN:
			begin
				statsHit = stage.valid && !anyOvf && stage.xBus < state_reg.threshold; // RL10 RL11
				thrHwLoad = statsHit; // RL10
			end
			mrssm_pkg::MODE_OVER:
			begin
				statsHit = stage.valid && (stage.xBus > state_reg.threshold || stage.posOvf); // RL12
			end
			mrssm_pkg::MODE_UNDER:
			begin
				statsHit = stage.valid && stage.xBus < state_reg.threshold; // RL13
			end
			default:
			begin
				statsHit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		state_next = state_reg;
		// One wait cycle per access; the request commits when waitrequest is low
		state_next.waitReq = ~busAccept;
		if (busAccept && read)
		begin
			state_next.readData = readMux;
		end
		if (busCommit && write)
		begin
			case (address)
				mrssm_pkg::OFF_INPUT_CTRL:
					state_next.inputCtrl = mergedWrite[mrssm_pkg::CTRL_W-1:0];
				mrssm_pkg::OFF_STATS_MODE:
					state_next.statsMode = mergedWrite[mrssm_pkg::MODE_W-1:0]; // RL8
				mrssm_pkg::OFF_THR_BUF:
					state_next.thresholdBuffer = mergedWrite[mrssm_pkg::X_W+1:0];
				mrssm_pkg::OFF_CNT_BUF:
					state_next.counterBuffer = mergedWrite[CNT_W-1:0];
				default:
					state_next.inputCtrl = state_reg.inputCtrl;
			endcase
		end
		if (thrHwLoad)
		begin
			state_next.threshold = stage.xBus; // RL9 RL10
		end
		if (statsHit && state_reg.eventCount != '1)
		begin
			state_next.eventCount = state_reg.eventCount + CNT_W'(1); // RL14
		end
		if (thrCopyWr)
		begin
			if (writedata[mrssm_pkg::COPY_CAPTURE_BIT])
			begin
				state_next.thresholdBuffer = {state_reg.negFlag, state_reg.posFlag,
					state_reg.threshold}; // RL15 RL17
			end
			else
			begin
				// Software load beats a same-cycle tracking update
				state_next.threshold = state_reg.thresholdBuffer[mrssm_pkg::X_W-1:0]; // RL17 RL18
			end
			state_next.posFlag = 1'b0; // RL16
			state_next.negFlag = 1'b0; // RL16
		end
		if (cntCopyWr)
		begin
			if (writedata[mrssm_pkg::COPY_CAPTURE_BIT])
			begin
				state_next.counterBuffer = state_reg.eventCount; // RL17
			end
			else
			begin
				state_next.eventCount = state_reg.counterBuffer; // RL17
			end
		end
		// A new overflow outweighs a clear in the same cycle
		if (stage.valid && stage.posOvf)
		begin
			state_next.posFlag = 1'b1; // RL15
		end
		if (stage.valid && stage.negOvf)
		begin
			state_next.negFlag = 1'b1; // RL15
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg.inputCtrl <= mrssm_pkg::INPUT_CTRL_RST;
			state_reg.statsMode <= mrssm_pkg::STATS_MODE_RST;
			state_reg.thresholdBuffer <= '0;
			state_reg.counterBuffer <= '0;
			state_reg.threshold <= mrssm_pkg::THR_RST; // RL21
			state_reg.posFlag <= 1'b0; // RL21
			state_reg.negFlag <= 1'b0; // RL21
			state_reg.eventCount <= '0; // RL21
			state_reg.waitReq <= 1'b1;
			state_reg.readData <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign readdata = state_reg.readData;
	assign waitrequest = state_reg.waitReq;
	assign xBus = stage.xBus; // RL19
	assign xValid = stage.valid;
	assign posOverflow = stage.posOvf;
	assign negOverflow = stage.negOvf;

	// ==========================================================
	// Checks
	property p_bus_answer;
		@(posedge clk) disable iff (reset)
		busReq && waitrequest |=> !waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) // RL17
		else $error("bus request not answered after one wait cycle");

	property p_max_load;
		@(posedge clk) disable iff (reset)
		state_reg.statsMode == mrssm_pkg::MODE_MAX && stage.valid && !anyOvf
			&& stage.xBus > state_reg.threshold && !thrCopyWr
			|=> state_reg.threshold == $past(stage.xBus);
	endproperty
	a_max_load: assert property (p_max_load) // RL9
		else $error("max tracking did not load threshold");

	property p_min_load;
		@(posedge clk) disable iff (reset)
		state_reg.statsMode == mrssm_pkg::MODE_MIN && stage.valid && !anyOvf
			&& stage.xBus < state_reg.threshold && !thrCopyWr
			|=> state_reg.threshold == $past(stage.xBus);
	endproperty
	a_min_load: assert property (p_min_load) // RL10
		else $error("min tracking did not load threshold");

	property p_ovf_hold;
		@(posedge clk) disable iff (reset)
		!state_reg.statsMode[1] && stage.valid && anyOvf && !thrCopyWr
			|=> $stable(state_reg.threshold);
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) // RL11
		else $error("threshold changed during overflow");

	property p_over_count;
		@(posedge clk) disable iff (reset)
		state_reg.statsMode == mrssm_pkg::MODE_OVER && stage.valid && stage.posOvf
			&& state_reg.eventCount != '1 && !cntCopyWr
			|=> state_reg.eventCount == $past(state_reg.eventCount) + CNT_W'(1);
	endproperty
	a_over_count: assert property (p_over_count) // RL12
		else $error("overshoot not counted on positive overflow");

	property p_saturate;
		@(posedge clk) disable iff (reset)
		state_reg.eventCount == '1 && !cntCopyWr |=> state_reg.eventCount == '1;
	endproperty
	a_saturate: assert property (p_saturate) // RL14
		else $error("event counter wrapped");

	property p_sticky_set;
		@(posedge clk) disable iff (reset)
		stage.valid && stage.posOvf |=> state_reg.posFlag ##1 (state_reg.posFlag || $past(thrCopyWr));
	endproperty
	a_sticky_set: assert property (p_sticky_set) // RL15
		else $error("positive overflow flag not sticky");

	property p_flag_clear;
		@(posedge clk) disable iff (reset)
		thrCopyWr && !(stage.valid && stage.negOvf) |=> !state_reg.negFlag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) // RL16
		else $error("copy write did not clear negative flag");
endmodule
`default_nettype wire

// file: tb/mrssm_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Array and cascade source model
module mrssm_array_model #(
	parameter int ARRAY_W = 32
)(
	input wire logic clk,
	output logic signed [ARRAY_W-1:0] macResult,
	output logic signed [mrssm_pkg::X_W-1:0] cascadeIn,
	output logic sampleValid
);
	typedef struct packed
	{
		logic [ARRAY_W-1:0] mac;
		logic [mrssm_pkg::X_W-1:0] casc;
		logic [3:0] gap;
	} mrssm_item_t;
	mrssm_item_t q[$];
	int idleCnt;
	initial
	begin
		macResult = '0;
		cascadeIn = '0;
		sampleValid = 1'b0;
		idleCnt = 0;
	end
	// Idle cycles flip both buses so a stale value never looks like a sample
	always @(posedge clk)
	begin
		if (q.size() > 0 && idleCnt >= int'(q[0].gap))
		begin
			sampleValid <= 1'b1;
			macResult <= q[0].mac;
			cascadeIn <= q[0].casc;
			void'(q.pop_front());
			idleCnt <= 0;
		end
		else
		begin
			sampleValid <= 1'b0;
			macResult <= ~macResult;
			cascadeIn <= ~cascadeIn;
			idleCnt <= idleCnt + 1;
		end
	end
	// Gap is the least number of idle cycles before this sample
	task automatic push(input logic [ARRAY_W-1:0] m, input logic [mrssm_pkg::X_W-1:0] c,
		input logic [3:0] g);
		@(negedge clk);
		q.push_back('{m, c, g});
	endtask
endmodule
`default_nettype wire

// file: tb/mac_result_scaler_and_stats_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mac_result_scaler_and_stats_monitor_tb_top;
	logic clk, reset, read, write, waitrequest, sampleValid, xValid, posOverflow, negOverflow;
	logic [7:0] address;
	logic [31:0] writedata, readdata, rdv;
	logic [3:0] byteenable;
	logic signed [31:0] macResult;
	logic signed [21:0] cascadeIn, xBus;
	int failures, testsRun;
	logic [7:0] ctrlNow, cntExp;
	logic [1:0] modeNow;
	logic signed [21:0] thrExp;
	logic posExp, negExp;
	logic [23:0] expQ[$];
	logic [61:0] dp [12] = '{{8'h10, 32'h00000001, 22'h000123}, {8'h30, 32'h00000180, 22'h000000},
		{8'h3F, 32'hFFFFFFFD, 22'h000005}, {8'h1E, 32'h00000003, 22'h000000},
		{8'h20, 32'h00001000, 22'h000000}, {8'h01, 32'h001FFFFF, 22'h000001},
		{8'h01, 32'hFFE00000, 22'h3FFFFF}, {8'h40, 32'hFFFFFFFB, 22'h000000},
		{8'h40, 32'h00000007, 22'h000000}, {8'h80, 32'hFFFFFFFB, 22'h000000},
		{8'hC0, 32'hFFE00000, 22'h000000}, {8'h10, 32'h01000001, 22'h000000}};
	logic [31:0] ss [7] = '{32'h0000000A, 32'hFFFFFFEC, 32'h00300000, 32'h00000032,
		32'hFFC00000, 32'h0000001E, 32'hFFFFFFD8};
	logic [31:0] ps [5] = '{{2'h1, 22'h200000, 8'h00}, {2'h0, 22'h1FFFFF, 8'h00},
		{2'h3, 22'h000014, 8'h00}, {2'h2, 22'h000000, 8'h00}, {2'h3, 22'h000000, 8'hFD}};

	mrssm_scaler_stats #(.ARRAY_W(32), .CNT_W(8)) u_mrssm_scaler_stats (.clk(clk), .reset(reset),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.macResult(macResult), .cascadeIn(cascadeIn), .sampleValid(sampleValid), .xBus(xBus),
		.xValid(xValid), .posOverflow(posOverflow), .negOverflow(negOverflow));
	mrssm_array_model #(.ARRAY_W(32)) u_mrssm_array_model (.clk(clk), .macResult(macResult),
		.cascadeIn(cascadeIn), .sampleValid(sampleValid));

	// ==========================================================
	// Checking and bus tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		@(posedge clk);
		while (waitrequest !== 1'b0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 40)
			check(32'h0000DEAD, 32'h00000000);
		rdv = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h00000000);
		check(rdv, exp);
	endtask
	// ==========================================================
	// Reference model of one sample
	function automatic logic [23:0] calc(input logic [7:0] ct, input logic signed [31:0] m,
		input logic signed [21:0] c);
		int sh;
		logic signed [31:0] t;
		longint s;
		logic r;
		logic [21:0] x;
		sh = $signed(ct[5:1]);
		if (sh > 8) sh = 8;
		if (sh < -8) sh = -8;
		r = 1'b0;
		if (sh >= 0)
			t = m <<< sh;
		else
		begin
			t = m >>> (-sh);
			r = m[-sh-1];
		end
		s = longint'(t) + longint'(r) + (ct[0] ? longint'(c) : 64'sh0);
		x = s[21:0];
		if (ct[7] && x[21] && x !== mrssm_pkg::X_MIN_BITS)
			x = -x;
		else if (!ct[7] && ct[6] && x[21])
			x = 22'h000000;
		return {s < mrssm_pkg::X_MIN, s > mrssm_pkg::X_MAX, x};
	endfunction
	task automatic send(input logic [31:0] m, input logic [21:0] c, input logic [3:0] g);
		logic [23:0] e;
		logic signed [21:0] x;
		logic ovf, bump;
		e = calc(ctrlNow, m, c);
		x = e[21:0];
		ovf = e[22] | e[23];
		bump = 1'b0;
		case (modeNow)
			2'b01:
				if (!ovf && x > thrExp)
				begin
					thrExp = x;
					bump = 1'b1;
				end
			2'b00:
				if (!ovf && x < thrExp)
				begin
					thrExp = x;
					bump = 1'b1;
				end
			2'b11: bump = (x > thrExp) || e[22];
			default: bump = x < thrExp;
		endcase
		if (bump && cntExp !== 8'hFF) cntExp++;
		posExp |= e[22];
		negExp |= e[23];
		expQ.push_back(e);
		u_mrssm_array_model.push(m, c, g);
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (u_mrssm_array_model.q.size() > 0 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		check(32'(expQ.size()), 32'h00000000);
	endtask
	task print_verdict;
		$display("Counts: checks=%0d mismatches=%0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// Output monitor
	always @(posedge clk)
	begin
		if (xValid === 1'b1 && expQ.size() == 0)
			check(32'h00000001, 32'h00000000);
		else if (xValid === 1'b1)
		begin
			check({8'h00, negOverflow, posOverflow, xBus}, {8'h00, expQ.pop_front()});
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Generous bound: the sequence below needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		failures = 0;
		testsRun = 0;
		reset = 1'b1;
		{read, write, address, writedata} = '0;
		byteenable = 4'hF;
		{ctrlNow, modeNow, thrExp, cntExp, posExp, negExp} = '0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a <= 28; a += 4) rd(8'(a), 32'h00000000);
		bus_xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
		rd(8'h1C, 32'h00000000);
		bus_xfer(1'b1, 8'h00, 32'hFFFFFFFF);
		rd(8'h00, 32'h000000FF);
		// Lane 0 disabled: the control byte must survive this write
		byteenable <= 4'hE;
		bus_xfer(1'b1, 8'h00, 32'h00000000);
		byteenable <= 4'hF;
		rd(8'h00, 32'h000000FF);
		bus_xfer(1'b1, 8'h04, 32'hFFFFFFFF);
		rd(8'h04, 32'h00000003);
		bus_xfer(1'b1, 8'h08, 32'h00000123);
		bus_xfer(1'b1, 8'h0C, 32'h00000001);
		rd(8'h08, 32'h00000000);
		$display("Test registers done");
		for (int i = 0; i < 12; i++)
		begin
			ctrlNow = dp[i][61:54];
			bus_xfer(1'b1, 8'h00, {24'h000000, ctrlNow});
			send(dp[i][53:22], dp[i][21:0], 4'h0);
			drain();
		end
		$display("Test datapath done");
		for (int p = 0; p < 5; p++)
		begin
			ctrlNow = 8'h00;
			bus_xfer(1'b1, 8'h00, 32'h00000000);
			modeNow = ps[p][31:30];
			bus_xfer(1'b1, 8'h04, {30'h00000000, modeNow});
			thrExp = ps[p][29:8];
			cntExp = ps[p][7:0];
			bus_xfer(1'b1, 8'h08, {10'h000, thrExp});
			bus_xfer(1'b1, 8'h0C, 32'h00000000);
			bus_xfer(1'b1, 8'h10, {24'h000000, cntExp});
			bus_xfer(1'b1, 8'h14, 32'h00000000);
			{posExp, negExp} = 2'h0;
			for (int i = 0; i < 7; i++) send(ss[i], 22'h000000, 4'(i % 3));
			drain();
			bus_xfer(1'b1, 8'h0C, 32'h00000001);
			rd(8'h08, {8'h00, negExp, posExp, thrExp});
			bus_xfer(1'b1, 8'h14, 32'h00000001);
			rd(8'h10, {24'h000000, cntExp});
			bus_xfer(1'b1, 8'h0C, 32'h00000001);
			rd(8'h08, {10'h000, thrExp});
		end
		$display("Test statistics done");
		print_verdict();
	end
endmodule
`default_nettype wire
